// *** rtl/xss_save_unit.v ***
// Extended state save unit: fault checks, header bitmaps and store selection
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "xss_regs.vh"
module xss_save_unit #(
    parameter AW = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Avalon-MM slave
    input wire [AW-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Save area header port
    output reg hdr_rd,
    output reg hdr_wr_state,
    output reg hdr_wr_comp,
    output reg [63:0] hdr_wr_state_data,
    output reg [63:0] hdr_wr_comp_data,
    input wire [63:0] hdr_rd_data,
    // Component store strobes
    output reg comp_store,
    output reg [63:0] comp_store_mask,
    output reg compacted_layout,
    output reg simd_store
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 5'h01;
    localparam ST_CHECK = 5'h02;
    localparam ST_RDHDR = 5'h04;
    localparam ST_WRITE = 5'h08;
    localparam ST_DONE = 5'h10;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    reg [31:0] ctrl;
    reg [63:0] ext_feature_ctrl;
    reg [63:0] instr_mask;
    reg [63:0] area_addr;
    reg [63:0] in_use_tracker;
    reg [63:0] modified_tracker;
    reg [31:0] simd_control_status;
    reg [31:0] rinfo_ctl;
    reg [63:0] rinfo_addr;
    reg [63:0] rinfo_comp;
    reg [7:0] status;
    reg [4:0] state;
    reg [3:0] wait_cnt;
    reg [63:0] requested_feature_bitmap;
    // Bitmaps are formed combinationally and land straight in the port copies
    reg mod_opt;
    reg start_pend;
    wire [63:0] hdr_q;
    wire [63:0] cmp_q;
    wire [63:0] saved_q;

    // Decoded controls
    wire compact = ctrl[`XSS_CTRL_COMPACT];
    wire [1:0] current_privilege_level = ctrl[`XSS_CTRL_CPL+1:`XSS_CTRL_CPL];
    wire simd_not_init = (simd_control_status != `XSS_SIMD_INIT);
    wire misaligned = |area_addr[`XSS_ALIGN_BITS-1:0];
    wire ac_sel = ctrl[`XSS_CTRL_AM] & ctrl[`XSS_CTRL_AC] & (current_privilege_level == `XSS_CPL_USER);
    wire [63:0] next_requested_feature_bitmap = ext_feature_ctrl & instr_mask;

    // ----------------------------------------
    // Header and result capture registers
    // ----------------------------------------
    xss_hdr_reg #(.WIDTH(64)) u_hdr (
        .sys_clk(sys_clk),
        .srst(srst),
        .load(hdr_wr_state),
        .load_data(hdr_wr_state_data),
        .q(hdr_q)
    );
    xss_hdr_reg #(.WIDTH(64)) u_cmp (
        .sys_clk(sys_clk),
        .srst(srst),
        .load(hdr_wr_comp),
        .load_data(hdr_wr_comp_data),
        .q(cmp_q)
    );
    xss_hdr_reg #(.WIDTH(64)) u_saved (
        .sys_clk(sys_clk),
        .srst(srst),
        .load(comp_store),
        .load_data(comp_store_mask),
        .q(saved_q)
    );

    // Modified optimization qualification against the restore record
    wire rec_match = (rinfo_ctl[`XSS_RI_CPL+1:`XSS_RI_CPL] == current_privilege_level) &&
        (rinfo_ctl[`XSS_RI_NONROOT] == ctrl[`XSS_CTRL_NONROOT]) &&
        (rinfo_addr == area_addr) &&
        (rinfo_comp == 64'h0000000000000000);

    // ----------------------------------------
    // Bitmap formation
    // ----------------------------------------
    reg [63:0] next_state_bm;
    reg [63:0] next_saved_bm;
    reg next_simd_req;
    always @* begin
        next_state_bm = 64'h0000000000000000;
        next_saved_bm = 64'h0000000000000000;
        next_simd_req = 1'b0;
        if (compact) begin
            // Unrequested bits written as 0, requested from in-use
            next_state_bm = requested_feature_bitmap & in_use_tracker;
            if (requested_feature_bitmap[1] && simd_not_init) begin
                next_state_bm[1] = 1'b1;
            end
            // Store set equals the written header bitmap
            next_saved_bm = next_state_bm;
            next_simd_req = requested_feature_bitmap[1];
        end else begin
            // Keep unrequested bits read from memory
            next_state_bm = (hdr_rd_data & ~requested_feature_bitmap) | (requested_feature_bitmap & in_use_tracker);
            next_saved_bm = requested_feature_bitmap & in_use_tracker;
            if (mod_opt) begin
                next_saved_bm = next_saved_bm & modified_tracker;
            end
            next_simd_req = requested_feature_bitmap[1] | requested_feature_bitmap[2];
        end
    end

    // ----------------------------------------
    // Save sequencer
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            status <= 8'h00;
            requested_feature_bitmap <= 64'h0000000000000000;
            mod_opt <= 1'b0;
            wait_cnt <= 4'h0;
            hdr_rd <= 1'b0;
            hdr_wr_state <= 1'b0;
            hdr_wr_comp <= 1'b0;
            hdr_wr_state_data <= 64'h0000000000000000;
            hdr_wr_comp_data <= 64'h0000000000000000;
            comp_store <= 1'b0;
            comp_store_mask <= 64'h0000000000000000;
            compacted_layout <= 1'b0;
            simd_store <= 1'b0;
        end else begin
            hdr_wr_state <= 1'b0;
            hdr_wr_comp <= 1'b0;
            comp_store <= 1'b0;
            simd_store <= 1'b0;
            hdr_rd <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_pend) begin
                        status <= 8'h01;
                        requested_feature_bitmap <= next_requested_feature_bitmap;
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    // Faults resolved before any header or component write
                    if (!ctrl[`XSS_CTRL_OSEN]) begin
                        status <= 8'h06;
                        state <= ST_IDLE;
                    end else if (ctrl[`XSS_CTRL_CR0+`XSS_CTRL_TS]) begin
                        status <= 8'h0A;
                        state <= ST_IDLE;
                    end else if (misaligned) begin
                        status <= ac_sel ? 8'h22 : 8'h12;
                        state <= ST_IDLE;
                    end else begin
                        mod_opt <= ~compact & rec_match;
                        wait_cnt <= `XSS_HDR_RD_CYCLES;
                        hdr_rd <= ~compact;
                        state <= compact ? ST_WRITE : ST_RDHDR;
                    end
                end
                ST_RDHDR: begin
                    // Give the memory side time to return header data
                    if (wait_cnt == 4'h1) begin
                        state <= ST_WRITE;
                    end else begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                end
                ST_WRITE: begin
                    hdr_wr_state <= 1'b1;
                    hdr_wr_state_data <= next_state_bm;
                    hdr_wr_comp <= compact;
                    hdr_wr_comp_data <= {1'b1, requested_feature_bitmap[62:0]};
                    comp_store <= 1'b1;
                    comp_store_mask <= next_saved_bm;
                    compacted_layout <= compact;
                    simd_store <= next_simd_req;
                    status[`XSS_ST_MODOPT] <= mod_opt;
                    status[`XSS_ST_SIMD] <= next_simd_req;
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    status[`XSS_ST_BUSY] <= 1'b0;
                    status[`XSS_ST_DONE] <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Avalon-MM slave: one wait cycle, then answer
    // ----------------------------------------
    wire req = avs_read | avs_write;
    wire accept = req & avs_waitrequest & ~srst;
    reg [31:0] rd_mux;
    always @* begin
        case (avs_address)
            `XSS_CTRL_OFS: rd_mux = ctrl;
            `XSS_STATUS_OFS: rd_mux = {24'h000000, status};
            `XSS_XCR_LO_OFS: rd_mux = ext_feature_ctrl[31:0];
            `XSS_XCR_HI_OFS: rd_mux = ext_feature_ctrl[63:32];
            `XSS_MASK_LO_OFS: rd_mux = instr_mask[31:0];
            `XSS_MASK_HI_OFS: rd_mux = instr_mask[63:32];
            `XSS_AREA_LO_OFS: rd_mux = area_addr[31:0];
            `XSS_AREA_HI_OFS: rd_mux = area_addr[63:32];
            `XSS_INUSE_LO_OFS: rd_mux = in_use_tracker[31:0];
            `XSS_INUSE_HI_OFS: rd_mux = in_use_tracker[63:32];
            `XSS_MOD_LO_OFS: rd_mux = modified_tracker[31:0];
            `XSS_MOD_HI_OFS: rd_mux = modified_tracker[63:32];
            `XSS_SIMD_OFS: rd_mux = simd_control_status;
            `XSS_RINFO_CTL_OFS: rd_mux = rinfo_ctl;
            `XSS_RINFO_ADR_LO_OFS: rd_mux = rinfo_addr[31:0];
            `XSS_RINFO_ADR_HI_OFS: rd_mux = rinfo_addr[63:32];
            `XSS_RINFO_CMP_LO_OFS: rd_mux = rinfo_comp[31:0];
            `XSS_RINFO_CMP_HI_OFS: rd_mux = rinfo_comp[63:32];
            `XSS_HDR_LO_OFS: rd_mux = hdr_q[31:0];
            `XSS_HDR_HI_OFS: rd_mux = hdr_q[63:32];
            `XSS_CMP_LO_OFS: rd_mux = cmp_q[31:0];
            `XSS_CMP_HI_OFS: rd_mux = cmp_q[63:32];
            `XSS_SAVED_LO_OFS: rd_mux = saved_q[31:0];
            `XSS_SAVED_HI_OFS: rd_mux = saved_q[63:32];
            default: rd_mux = `XSS_READ_ZERO;
        endcase
    end

    // Waitrequest drops for one cycle after each request is seen
    always @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `XSS_READ_ZERO;
        end else begin
            avs_waitrequest <= ~accept;
            if (accept && avs_read) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Register writes take effect at the answering edge
    wire wr_take = avs_write & ~avs_waitrequest;
    always @(posedge sys_clk) begin
        if (srst) begin
            ctrl <= `XSS_CTRL_RST;
            ext_feature_ctrl <= 64'h0000000000000000;
            instr_mask <= 64'h0000000000000000;
            area_addr <= 64'h0000000000000000;
            in_use_tracker <= 64'h0000000000000000;
            modified_tracker <= 64'h0000000000000000;
            simd_control_status <= `XSS_SIMD_INIT;
            rinfo_ctl <= 32'h00000000;
            rinfo_addr <= 64'h0000000000000000;
            rinfo_comp <= 64'h0000000000000000;
            start_pend <= 1'b0;
        end else begin
            // Start request written in ST_IDLE held until the sequencer takes it; one written while busy is dropped
            if (state == ST_IDLE) begin
                start_pend <= 1'b0;
            end
            if (wr_take) begin
                case (avs_address)
                    `XSS_CTRL_OFS: begin
                        ctrl <= avs_writedata & 32'hFFFFFFFE;
                        if (avs_writedata[`XSS_CTRL_START] && state == ST_IDLE) begin
                            start_pend <= 1'b1;
                        end
                    end
                    `XSS_XCR_LO_OFS: ext_feature_ctrl[31:0] <= avs_writedata;
                    `XSS_XCR_HI_OFS: ext_feature_ctrl[63:32] <= avs_writedata;
                    `XSS_MASK_LO_OFS: instr_mask[31:0] <= avs_writedata;
                    `XSS_MASK_HI_OFS: instr_mask[63:32] <= avs_writedata;
                    `XSS_AREA_LO_OFS: area_addr[31:0] <= avs_writedata;
                    `XSS_AREA_HI_OFS: area_addr[63:32] <= avs_writedata;
                    `XSS_INUSE_LO_OFS: in_use_tracker[31:0] <= avs_writedata;
                    `XSS_INUSE_HI_OFS: in_use_tracker[63:32] <= avs_writedata;
                    `XSS_MOD_LO_OFS: modified_tracker[31:0] <= avs_writedata;
                    `XSS_MOD_HI_OFS: modified_tracker[63:32] <= avs_writedata;
                    `XSS_SIMD_OFS: simd_control_status <= avs_writedata;
                    `XSS_RINFO_CTL_OFS: rinfo_ctl <= avs_writedata;
                    `XSS_RINFO_ADR_LO_OFS: rinfo_addr[31:0] <= avs_writedata;
                    `XSS_RINFO_ADR_HI_OFS: rinfo_addr[63:32] <= avs_writedata;
                    `XSS_RINFO_CMP_LO_OFS: rinfo_comp[31:0] <= avs_writedata;
                    `XSS_RINFO_CMP_HI_OFS: rinfo_comp[63:32] <= avs_writedata;
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // xss_save_unit

// *** rtl/xss_regs.vh ***
// Constants for the extended state save unit
`ifndef XSS_REGS_VH
`define XSS_REGS_VH
// ----------------------------------------
// Register map (bus word byte addresses)
// ----------------------------------------
`define XSS_CTRL_OFS 8'h00
`define XSS_STATUS_OFS 8'h04
`define XSS_XCR_LO_OFS 8'h08
`define XSS_XCR_HI_OFS 8'h0C
`define XSS_MASK_LO_OFS 8'h10
`define XSS_MASK_HI_OFS 8'h14
`define XSS_AREA_LO_OFS 8'h18
`define XSS_AREA_HI_OFS 8'h1C
`define XSS_INUSE_LO_OFS 8'h20
`define XSS_INUSE_HI_OFS 8'h24
`define XSS_MOD_LO_OFS 8'h28
`define XSS_MOD_HI_OFS 8'h2C
`define XSS_SIMD_OFS 8'h30
`define XSS_RINFO_CTL_OFS 8'h34
`define XSS_RINFO_ADR_LO_OFS 8'h38
`define XSS_RINFO_ADR_HI_OFS 8'h3C
`define XSS_RINFO_CMP_LO_OFS 8'h40
`define XSS_RINFO_CMP_HI_OFS 8'h44
`define XSS_HDR_LO_OFS 8'h48
`define XSS_HDR_HI_OFS 8'h4C
`define XSS_CMP_LO_OFS 8'h50
`define XSS_CMP_HI_OFS 8'h54
`define XSS_SAVED_LO_OFS 8'h58
`define XSS_SAVED_HI_OFS 8'h5C
`define XSS_READ_ZERO 32'h00000000
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define XSS_CTRL_START 0
`define XSS_CTRL_COMPACT 1
`define XSS_CTRL_OSEN 2
`define XSS_CTRL_CR0 4
`define XSS_CTRL_TS 3
`define XSS_CTRL_AM 8
`define XSS_CTRL_AC 9
`define XSS_CTRL_NONROOT 10
`define XSS_CTRL_CPL 12
// Status fields
`define XSS_ST_BUSY 0
`define XSS_ST_DONE 1
`define XSS_ST_UD 2
`define XSS_ST_NM 3
`define XSS_ST_GP 4
`define XSS_ST_AC 5
`define XSS_ST_MODOPT 6
`define XSS_ST_SIMD 7
// Restore record control fields
`define XSS_RI_CPL 0
`define XSS_RI_NONROOT 2
// ----------------------------------------
// Values
// ----------------------------------------
`define XSS_SIMD_INIT 32'h00001F80
`define XSS_ALIGN_BITS 6
`define XSS_CPL_USER 2'h3
`define XSS_CMP_FLAG 63
`define XSS_HDR_RD_CYCLES 4'h2
`define XSS_CTRL_RST 32'h00000000
`endif

// *** rtl/xss_hdr_reg.v ***
// Header bitmap holding register with bus-readable halves
`timescale 1ns/100ps
module xss_hdr_reg #(
    parameter WIDTH = 64
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Load port
    input wire load,
    input wire [WIDTH-1:0] load_data,
    // Stored value
    output reg [WIDTH-1:0] q
);
    // Holds the value until the next load
    always @(posedge sys_clk) begin
        if (srst) begin
            q <= {WIDTH{1'b0}};
        end else if (load) begin
            q <= load_data;
        end
    end
endmodule // xss_hdr_reg

// *** sim/xss_save_unit_checker.sv ***
// Concurrent checks on the ports of the save unit
`timescale 1ns/100ps
module xss_save_unit_checker #(
    parameter AW = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Register bus
    input wire [AW-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Header and store ports
    input wire hdr_rd,
    input wire hdr_wr_state,
    input wire hdr_wr_comp,
    input wire [63:0] hdr_wr_state_data,
    input wire [63:0] hdr_wr_comp_data,
    input wire [63:0] hdr_rd_data,
    input wire comp_store,
    input wire [63:0] comp_store_mask,
    input wire compacted_layout,
    input wire simd_store
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // Bus answers one cycle after taking a request, for one cycle
    AST_BUS_ANSWER: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");
    // The header read pulse leads the write-back pulse by three cycles
    AST_OPT_READ_FIRST: assert property (
        hdr_wr_state && !hdr_wr_comp |-> $past(hdr_rd, 3))
        else $error("header written back without read");
    AST_OPT_WRITEBACK: assert property (
        hdr_rd |-> ##3 (hdr_wr_state && !hdr_wr_comp))
        else $error("optimizing write back wrong");
    AST_CMP_NO_READ: assert property (
        hdr_wr_comp |-> !hdr_rd && !$past(hdr_rd, 1) && !$past(hdr_rd, 2))
        else $error("compacted save read the header");
    AST_CMP_FLAG: assert property (
        hdr_wr_comp |-> hdr_wr_comp_data[63] && hdr_wr_state)
        else $error("compaction flag missing");
    AST_CMP_STATE_SUB: assert property (
        hdr_wr_comp |-> (hdr_wr_state_data[62:0] & ~hdr_wr_comp_data[62:0]) == 63'h0)
        else $error("unrequested header bit set");
    AST_CMP_STORE_EQ: assert property (
        hdr_wr_comp && comp_store |-> comp_store_mask[62:0] == hdr_wr_state_data[62:0])
        else $error("compacted store differs from header");
    AST_STORE_IN_HDR: assert property (
        comp_store |-> (comp_store_mask & ~hdr_wr_state_data) == 64'h0)
        else $error("stored component not marked in header");
    AST_STORE_WITH_HDR: assert property (
        comp_store || simd_store |-> hdr_wr_state)
        else $error("store without header write");
    AST_LAYOUT: assert property (
        hdr_wr_state |=> compacted_layout == $past(hdr_wr_comp))
        else $error("layout flag wrong");
    // Main scenarios
    cover property (hdr_wr_comp && comp_store);
    cover property (hdr_rd ##3 simd_store);
    cover property (avs_write && !avs_waitrequest);
endmodule // xss_save_unit_checker

bind xss_save_unit xss_save_unit_checker #(.AW(AW)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hdr_rd(hdr_rd), .hdr_wr_state(hdr_wr_state),
    .hdr_wr_comp(hdr_wr_comp), .hdr_wr_state_data(hdr_wr_state_data),
    .hdr_wr_comp_data(hdr_wr_comp_data), .hdr_rd_data(hdr_rd_data),
    .comp_store(comp_store), .comp_store_mask(comp_store_mask),
    .compacted_layout(compacted_layout), .simd_store(simd_store));

// *** sim/xss_mem_model.sv ***
// Save area memory model facing the header and store ports
`timescale 1ns/100ps
module xss_mem_model (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Bench preset of the stored header
    input wire prep,
    input wire [63:0] prep_val,
    // Header and store ports
    input wire hdr_rd,
    input wire hdr_wr_state,
    input wire hdr_wr_comp,
    input wire [63:0] hdr_wr_state_data,
    input wire [63:0] hdr_wr_comp_data,
    input wire comp_store,
    input wire [63:0] comp_store_mask,
    input wire simd_store,
    output wire [63:0] hdr_rd_data,
    // Captured results and pulse counts
    output reg [63:0] mem_state,
    output reg [63:0] mem_comp,
    output reg [63:0] mem_mask,
    output reg [39:0] cnt
);
    reg rd_valid;
    // Outside the read window the data lines show no stale copy
    assign hdr_rd_data = rd_valid ? mem_state : ~mem_state;
    // Capture each pulse and count it
    always @(posedge sys_clk) begin
        if (srst || prep) begin
            mem_state <= prep_val;
            mem_comp <= 64'h0;
            mem_mask <= 64'h0;
            cnt <= 40'h0;
            rd_valid <= 1'b0;
        end else begin
            if (hdr_rd) begin
                rd_valid <= 1'b1;
                cnt[39:32] <= cnt[39:32] + 8'h01;
            end
            if (hdr_wr_state) begin
                rd_valid <= 1'b0;
                mem_state <= hdr_wr_state_data;
                cnt[31:24] <= cnt[31:24] + 8'h01;
            end
            if (hdr_wr_comp) begin
                mem_comp <= hdr_wr_comp_data;
                cnt[23:16] <= cnt[23:16] + 8'h01;
            end
            if (comp_store) begin
                mem_mask <= comp_store_mask;
                cnt[15:8] <= cnt[15:8] + 8'h01;
            end
            if (simd_store) begin
                cnt[7:0] <= cnt[7:0] + 8'h01;
            end
        end
    end
endmodule // xss_mem_model

// *** sim/extended_state_save_unit_test.sv ***
// Self-checking bench for the extended state save unit
`timescale 1ns/100ps
`include "xss_regs.vh"
module extended_state_save_unit_test;
    // Fault cases: control words and expected status
    localparam [223:0] FC = {32'h1304, 32'h3306, 32'h3104, 32'h84, 32'h86, 32'h2, 32'h0};
    localparam [55:0] FE = {8'h12, 8'h22, 8'h12, 8'h0A, 8'h0A, 8'h06, 8'h06};
    localparam [127:0] MC = {32'h4, 32'h404, 32'h1004, 32'h4};
    reg sys_clk = 1'b0;
    reg srst = 1'b1;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg prep = 1'b0;
    reg [63:0] prep_val = 64'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, hdr_rd, hdr_wr_state, hdr_wr_comp, comp_store;
    wire compacted_layout, simd_store;
    wire [63:0] hdr_wr_state_data, hdr_wr_comp_data, hdr_rd_data, comp_store_mask;
    wire [63:0] mem_state, mem_comp, mem_mask;
    wire [39:0] cnt;
    reg [31:0] rdv;
    integer err_count = 0;
    integer tests_run = 0;
    integer i;
    xss_save_unit dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hdr_rd(hdr_rd),
        .hdr_wr_state(hdr_wr_state), .hdr_wr_comp(hdr_wr_comp),
        .hdr_wr_state_data(hdr_wr_state_data), .hdr_wr_comp_data(hdr_wr_comp_data),
        .hdr_rd_data(hdr_rd_data), .comp_store(comp_store), .comp_store_mask(comp_store_mask),
        .compacted_layout(compacted_layout), .simd_store(simd_store));
    xss_mem_model mem (.sys_clk(sys_clk), .srst(srst), .prep(prep), .prep_val(prep_val),
        .hdr_rd(hdr_rd), .hdr_wr_state(hdr_wr_state), .hdr_wr_comp(hdr_wr_comp),
        .hdr_wr_state_data(hdr_wr_state_data), .hdr_wr_comp_data(hdr_wr_comp_data),
        .comp_store(comp_store), .comp_store_mask(comp_store_mask), .simd_store(simd_store),
        .hdr_rd_data(hdr_rd_data), .mem_state(mem_state), .mem_comp(mem_comp),
        .mem_mask(mem_mask), .cnt(cnt));
    // 20 MHz clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task end_sim;
        begin
            $display("checks %0d errors %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [8*8-1:0] name, input [63:0] seen, input [63:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task hang;
        begin
            err_count = err_count + 1;
            $display("[ERR] wait exp answer seen none");
            end_sim;
        end
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task bus(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            n = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0 && n < 40) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            if (n >= 40) hang;
            rdv = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task w64(input [7:0] a, input [63:0] v);
        begin
            bus(1'b1, a, v[31:0]);
            bus(1'b1, a + 8'h04, v[63:32]);
        end
    endtask
    task cfg(input [63:0] x, input [63:0] m, input [63:0] u);
        begin
            w64(`XSS_XCR_LO_OFS, x);
            w64(`XSS_MASK_LO_OFS, m);
            w64(`XSS_INUSE_LO_OFS, u);
        end
    endtask
    // Preset the area header, start a save and poll status until it settles
    task save(input [31:0] ctrl, input [63:0] hdr);
        integer n;
        begin
            prep_val <= hdr;
            prep <= 1'b1;
            @(posedge sys_clk);
            prep <= 1'b0;
            bus(1'b1, `XSS_CTRL_OFS, ctrl | 32'h1);
            n = 0;
            rdv = 32'h1;
            while ((rdv[0] !== 1'b0 || rdv[5:1] === 5'h00) && n < 20) begin
                bus(1'b0, `XSS_STATUS_OFS, 32'h0);
                n = n + 1;
            end
            if (n >= 20) hang;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task sc_reset;
        begin
            bus(1'b0, `XSS_SIMD_OFS, 32'h0);
            chk("simd_rst", rdv, 64'h1F80);
            bus(1'b1, 8'h60, 32'hFFFFFFFF);
            bus(1'b0, 8'h60, 32'h0);
            chk("unmapped", rdv, 64'h0);
        end
    endtask
    task sc_faults;
        begin
            cfg(64'hFFFFFFFFFFFFFFFF, 64'hF, 64'hF);
            w64(`XSS_AREA_LO_OFS, 64'h2000);
            for (i = 0; i < 7; i = i + 1) begin
                if (i == 4) w64(`XSS_AREA_LO_OFS, 64'h2020);
                save(FC[i*32 +: 32], 64'h0);
                chk("flt_st", rdv, FE[i*8 +: 8]);
                chk("flt_cnt", cnt, 40'h0);
            end
        end
    endtask
    task sc_compact;
        begin
            cfg(64'hFFFFFFFFFFFFFFFF, 64'hC00000000000000F, 64'h4000000000000005);
            w64(`XSS_AREA_LO_OFS, 64'h2000);
            w64(`XSS_RINFO_ADR_LO_OFS, 64'h2000);
            w64(`XSS_MOD_LO_OFS, 64'h1);
            bus(1'b1, `XSS_SIMD_OFS, 32'h1234);
            save(32'h6, 64'hFFFFFFFFFFFFFFFF);
            chk("c_mod", rdv[6], 1'b0);
            chk("c_hdr", mem_state, 64'h4000000000000007);
            chk("c_cmp", mem_comp, 64'hC00000000000000F);
            chk("c_mask", mem_mask, 64'h4000000000000007);
            chk("c_cnt", cnt[39:8], 32'h00010101);
            chk("c_lay", compacted_layout, 1'b1);
        end
    endtask
    task sc_compact_b2;
        begin
            w64(`XSS_MASK_LO_OFS, 64'h4);
            save(32'h6, 64'h0);
            chk("b2_hdr", mem_state, 64'h4);
            chk("b2_simd", cnt[7:0], 8'h00);
            chk("b2_cmp", mem_comp, 64'h8000000000000004);
        end
    endtask
    task sc_opt;
        begin
            w64(`XSS_MASK_LO_OFS, 64'h8000000000000006);
            w64(`XSS_RINFO_CMP_LO_OFS, 64'h1);
            save(32'h4, 64'h0F0F0000000000F8);
            chk("o_hdr", mem_state, 64'h0F0F0000000000FC);
            chk("o_mask", mem_mask, 64'h4);
            chk("o_cnt", cnt, 40'h0101000101);
            chk("o_lay", compacted_layout, 1'b0);
        end
    endtask
    task sc_opt_mod;
        begin
            w64(`XSS_MASK_LO_OFS, 64'h4);
            w64(`XSS_RINFO_CMP_LO_OFS, 64'h0);
            for (i = 0; i < 4; i = i + 1) begin
                if (i == 3) w64(`XSS_RINFO_ADR_LO_OFS, 64'h2040);
                save(MC[i*32 +: 32], 64'h0);
                chk("m_used", rdv[6], i == 0);
                chk("m_mask", mem_mask, (i == 0) ? 64'h0 : 64'h4);
                chk("m_simd", cnt[7:0], 8'h01);
            end
        end
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        sc_reset;
        sc_faults;
        sc_compact;
        sc_compact_b2;
        sc_opt;
        sc_opt_mod;
        end_sim;
    end
endmodule // extended_state_save_unit_test
